// ### lcx_decoder.sv
`timescale 1ns/100ps
module lcx_decoder (
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   input  wire logic             op_valid,
   input  wire lcx_pkg::lcx_op_type op_class,
   input  wire logic [31:0]      op_addr,
   input  wire logic [31:0]      target_addr,
   input  wire logic             skip_taken,
   input  wire logic [63:0]      mem_operand,
   input  wire logic [31:0]      acc_operand,
   input  wire logic             blk_descending,
   input  wire logic             blk_cross_seg,
   input  wire logic             flt_exc,
   input  wire logic             flt_result_zero,
   input  wire logic             flt_result_neg,
   input  wire logic             op_done,
   input  wire logic             psr_mask_in,
   output logic [1:0]            insn_len,
   output logic                  wide_sem,
   output logic                  ptr_double,
   output logic                  data_wide,
   output logic                  use_acc_wide,
   output logic [2:0]            ret_block_dw,
   output logic                  narrow_stack,
   output logic [31:0]           pc_q,
   output logic [63:0]           float_acc_q,
   output logic [63:0]           float_status_register,
   output logic [31:0]           fix_result_q,
   output logic [31:0]           second_accumulator,
   output logic                  prot_fault_q,
   output logic                  float_trap_q,
   output logic                  nonpriv_fault_q,
   output logic                  overflow_trap_mask
);

   logic [31:0] pc_d;
   logic [63:0] facc_d;
   logic [63:0] fsr_d;
   logic [31:0] fix_d;
   logic [31:0] ac1_d;
   logic [31:0] ac1_q;
   logic        prot_d;
   logic        trap_d;
   logic        npf_d;
   logic        ovk_d;
   logic        ovk_q;
   logic        fault_held_q;
   logic        fault_held_d;

   logic        is_wide;
   logic        is_fix;
   logic        fix_wide;
   logic signed [31:0] fix_int;
   logic        fix_ovf;

   localparam int FSR_SEG = lcx_pkg::LCX_FSR_FPC_LO;

   // Per-opcode decode: length, pointer size, data width
   always_comb begin
      is_wide      = 1'b0;
      insn_len     = lcx_pkg::LCX_LEN_ONE;
      ret_block_dw = 3'h0;
      use_acc_wide = 1'b0;
      case (op_class)
         lcx_pkg::LCX_OP_LLOAD_FSTAT,
         lcx_pkg::LCX_OP_LSTORE_FSTAT: begin
            is_wide  = 1'b1;
            insn_len = lcx_pkg::LCX_LEN_THREE;
         end
         lcx_pkg::LCX_OP_LOAD_FSTAT,
         lcx_pkg::LCX_OP_STORE_FSTAT: begin
            insn_len = lcx_pkg::LCX_LEN_TWO;
         end
         lcx_pkg::LCX_OP_XOP: begin
            insn_len = lcx_pkg::LCX_LEN_TWO;
         end
         lcx_pkg::LCX_OP_WIDE_EXTENDED_OPERATION_OP: begin
            is_wide  = 1'b1;
            insn_len = lcx_pkg::LCX_LEN_TWO;
         end
         lcx_pkg::LCX_OP_WRETURN,
         lcx_pkg::LCX_OP_WSAVE_STACK,
         lcx_pkg::LCX_OP_WSAVE_RETURN: begin
            is_wide      = 1'b1;
            ret_block_dw = lcx_pkg::LCX_WIDE_RET_BLOCK;
         end
         lcx_pkg::LCX_OP_WIDE_FIX_ACC,
         lcx_pkg::LCX_OP_WIDE_FLT_ACC: begin
            is_wide      = 1'b1;
            use_acc_wide = 1'b1;
         end
         lcx_pkg::LCX_OP_WJUMP: begin
            is_wide = 1'b1;
         end
         default: begin
            is_wide = 1'b0;
         end
      endcase
   end

   // Semantics follow each opcode, so the forms mix freely
   assign wide_sem     = is_wide;
   assign ptr_double   = is_wide;
   assign data_wide    = is_wide;
   assign narrow_stack = !is_wide;

   assign is_fix   = (op_class == lcx_pkg::LCX_OP_FIX_SINGLE) ||
                     (op_class == lcx_pkg::LCX_OP_FIX_DOUBLE) ||
                     (op_class == lcx_pkg::LCX_OP_FIX_TO_ACC) ||
                     (op_class == lcx_pkg::LCX_OP_FIX_TO_MEM) ||
                     (op_class == lcx_pkg::LCX_OP_WIDE_FIX_ACC);
   assign fix_wide = (op_class == lcx_pkg::LCX_OP_FIX_DOUBLE) ||
                     (op_class == lcx_pkg::LCX_OP_FIX_TO_MEM) ||
                     (op_class == lcx_pkg::LCX_OP_WIDE_FIX_ACC);

   // Operand layout: sign, 7-bit excess-64 hex exponent, fraction
   // Leading fraction bit weighs one half, hence one below 4*(e-64)
   lcx_fix_unit #(
      .MAG_W (64)
   ) u_fix (
      .sign_in (float_acc_q[63]),
      .exp_in  ($signed({1'b0, float_acc_q[62:56], 2'b00}) - 10'sd257),
      .mag_in  ({float_acc_q[55:0], 8'h00}),
      .wide_in (fix_wide),
      .int_out (fix_int),
      .ovf_out (fix_ovf)
   );

   // Next-state for the execution state
   always_comb begin
      pc_d         = pc_q;
      facc_d       = float_acc_q;
      fsr_d        = float_status_register;
      fix_d        = fix_result_q;
      ac1_d        = ac1_q;
      prot_d       = 1'b0;
      trap_d       = 1'b0;
      npf_d        = 1'b0;
      ovk_d        = ovk_q;
      fault_held_d = fault_held_q;
      if (op_valid) begin
         // Plain 32-bit add: no wrap at 7777 or 77777
         pc_d = pc_q + (skip_taken ? 32'(insn_len) + 32'h1 : 32'(insn_len));
         case (op_class)
            lcx_pkg::LCX_OP_FLOAD_SINGLE,
            lcx_pkg::LCX_OP_FLOAD_DOUBLE: begin
               facc_d = (op_class == lcx_pkg::LCX_OP_FLOAD_SINGLE) ?
                        {mem_operand[63:32], 32'h0} : mem_operand;
               // Flags meaningful only for a normalised operand
               fsr_d[63-lcx_pkg::LCX_FSR_Z] = (facc_d[62:0] == 63'h0);
               fsr_d[63-lcx_pkg::LCX_FSR_N] = facc_d[63];
            end
            lcx_pkg::LCX_OP_FIX_TO_ACC,
            lcx_pkg::LCX_OP_FIX_TO_MEM,
            lcx_pkg::LCX_OP_FIX_SINGLE,
            lcx_pkg::LCX_OP_FIX_DOUBLE,
            lcx_pkg::LCX_OP_WIDE_FIX_ACC: begin
               fix_d = fix_int;
               fsr_d[63-lcx_pkg::LCX_FSR_MOF] = fix_ovf;
               // Zero and negative flags left alone
            end
            lcx_pkg::LCX_OP_WIDE_FLT_ACC: begin
               facc_d = {acc_operand, 32'h0};
            end
            lcx_pkg::LCX_OP_FLOAT_ARITH: begin
               // Exact zero forced to true zero; rounding bit passes through
               facc_d = flt_result_zero ? 64'h0 : mem_operand;
               fsr_d[63-lcx_pkg::LCX_FSR_Z] = flt_result_zero;
               fsr_d[63-lcx_pkg::LCX_FSR_N] = flt_result_neg && !flt_result_zero;
            end
            lcx_pkg::LCX_OP_LOAD_FSTAT,
            lcx_pkg::LCX_OP_LLOAD_FSTAT: begin
               fsr_d = mem_operand;
            end
            lcx_pkg::LCX_OP_WRETURN,
            lcx_pkg::LCX_OP_WSAVE_STACK,
            lcx_pkg::LCX_OP_WSAVE_RETURN: begin
               ovk_d = psr_mask_in;
            end
            lcx_pkg::LCX_OP_JUMP: begin
               pc_d = {pc_q[31:28], 13'h0, target_addr[14:0]};
            end
            lcx_pkg::LCX_OP_WJUMP: begin
               pc_d = {pc_q[31:28], target_addr[27:0]};
            end
            lcx_pkg::LCX_OP_BLOCK_MOVE: begin
               if (blk_descending && blk_cross_seg) begin
                  prot_d = 1'b1;
                  ac1_d  = lcx_pkg::LCX_PROT_DESC_CROSS;
                  npf_d  = 1'b1;
               end
            end
            default: begin
               prot_d = 1'b0; // Other classes only advance the counter
            end
         endcase
      end
      // Float exception: record the first faulting address only
      if (op_valid && flt_exc) begin
         fsr_d[63-lcx_pkg::LCX_FSR_ANY] = 1'b1;
         if (!fault_held_q) begin
            fsr_d[64-FSR_SEG:0] = {1'b0, op_addr[30:0]};
            fault_held_d = 1'b1;
         end
      end
      // Trap at completion, not on the next float instruction
      if (op_done && fault_held_q && float_status_register[63-lcx_pkg::LCX_FSR_TE]) begin
         trap_d       = 1'b1;
         npf_d        = 1'b1;
         fault_held_d = 1'b0;
      end
   end

   // Registered execution state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pc_q                  <= lcx_pkg::LCX_PC_RESET;
         float_acc_q           <= 64'h0;
         float_status_register <= lcx_pkg::LCX_FSR_RESET;
         fix_result_q          <= 32'h0;
         ac1_q                 <= 32'h0;
         prot_fault_q          <= 1'b0;
         float_trap_q          <= 1'b0;
         nonpriv_fault_q       <= 1'b0;
         ovk_q                 <= 1'b0;
         fault_held_q          <= 1'b0;
      end else if (clk_en) begin
         pc_q                  <= pc_d;
         float_acc_q           <= facc_d;
         float_status_register <= fsr_d;
         fix_result_q          <= fix_d;
         ac1_q                 <= ac1_d;
         prot_fault_q          <= prot_d;
         float_trap_q          <= trap_d;
         nonpriv_fault_q       <= npf_d;
         ovk_q                 <= ovk_d;
         fault_held_q          <= fault_held_d;
      end
   end

   assign second_accumulator = ac1_q;
   assign overflow_trap_mask = ovk_q;

   // Checks on decode and sequencing
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_blk_bad;
      clk_en && op_valid && op_class == lcx_pkg::LCX_OP_BLOCK_MOVE &&
      blk_descending && blk_cross_seg;
   endsequence

   chk_long_status_len: assert property (
      op_class == lcx_pkg::LCX_OP_LLOAD_FSTAT |-> insn_len == 2'h3)
      else $error("long status op not three words");
   chk_xop_len: assert property (
      op_class == lcx_pkg::LCX_OP_WIDE_EXTENDED_OPERATION_OP || op_class == lcx_pkg::LCX_OP_XOP
      |-> insn_len == 2'h2)
      else $error("extended op not two words");
   chk_wide_ret_block: assert property (
      op_class == lcx_pkg::LCX_OP_WRETURN |-> ret_block_dw == 3'h6 && ptr_double)
      else $error("wide return block wrong");
   chk_prot_code: assert property (
      s_blk_bad |=> prot_fault_q && second_accumulator == 32'h4 && nonpriv_fault_q)
      else $error("protection fault code missing");
   chk_pc_no_wrap: assert property (
      clk_en && op_valid && op_class == lcx_pkg::LCX_OP_NONE && !skip_taken
      |=> pc_q == $past(pc_q) + 32'h1)
      else $error("program counter wrapped");
   chk_jump_format: assert property (
      clk_en && op_valid && op_class == lcx_pkg::LCX_OP_JUMP
      |=> pc_q[27:15] == 13'h0 && pc_q[31:28] == $past(pc_q[31:28]))
      else $error("legacy jump pc format wrong");
   chk_fix_keeps_flags: assert property (
      clk_en && op_valid && op_class == lcx_pkg::LCX_OP_FIX_TO_ACC && !flt_exc
      |=> $stable(float_status_register[57:56]))
      else $error("fix changed zero or negative flag");
   chk_load_copies: assert property (
      clk_en && op_valid && op_class == lcx_pkg::LCX_OP_FLOAD_DOUBLE
      |=> float_acc_q == $past(mem_operand))
      else $error("float load altered operand");
   chk_fix_range: assert property (
      fix_int < lcx_pkg::LCX_SINGLE_MIN && !fix_wide && is_fix |-> fix_ovf)
      else $error("single fix out of range");
   chk_narrow_stack: assert property (
      s_blk_bad |-> narrow_stack ##1 nonpriv_fault_q)
      else $error("legacy op not on narrow stack");

   // Sequencing checks on faults, traps, the single load and the counter
   // Trap follows completion by exactly one cycle
   chk_trap_timing: assert property (
      clk_en && op_done && fault_held_q && float_status_register[63-lcx_pkg::LCX_FSR_TE]
      |=> float_trap_q && nonpriv_fault_q)
      else $error("float trap not taken at completion");
   // A later fault must not move the recorded address
   chk_first_fault: assert property (
      clk_en && op_valid && flt_exc && fault_held_q &&
      op_class == lcx_pkg::LCX_OP_FLOAT_ARITH
      |=> float_status_register[31:0] == $past(float_status_register[31:0]))
      else $error("fault address overwritten");
   // Skip adds one word on top of the two-word length
   chk_skip_step: assert property (
      clk_en && op_valid && skip_taken && op_class == lcx_pkg::LCX_OP_XOP
      |=> pc_q == $past(pc_q) + 32'h3)
      else $error("skip did not pass the next word");
   // Single load keeps the high word and clears the low word
   chk_single_load: assert property (
      clk_en && op_valid && op_class == lcx_pkg::LCX_OP_FLOAD_SINGLE
      |=> float_acc_q == {$past(mem_operand[63:32]), 32'h0})
      else $error("single float load altered operand");
   // Clock enable low must hold the counter
   chk_freeze_pc: assert property (
      !clk_en |=> pc_q == $past(pc_q))
      else $error("counter moved while clock enable low");

endmodule // lcx_decoder

// ### lcx_fix_unit.sv
`timescale 1ns/100ps
// Truncating float-to-integer conversion; out of range gives zero and sets ovf_out.
// Input: sign, unbiased exponent and a left-aligned magnitude.
module lcx_fix_unit #(
   parameter int MAG_W = 64
) (
   input  wire logic             sign_in,
   input  wire logic signed [9:0] exp_in,
   input  wire logic [MAG_W-1:0] mag_in,
   input  wire logic             wide_in,
   output logic signed [31:0]    int_out,
   output logic                  ovf_out
);

   logic [MAG_W-1:0] shifted;
   logic [32:0]      whole;
   logic [32:0]      lim;

   // Integer part only: drop fraction bits by right shift
   always_comb begin
      shifted = '0;
      whole   = '0;
      lim     = wide_in ? 33'h080000000 : 33'h000008000;
      ovf_out = 1'b0;
      int_out = '0;
      if (exp_in >= 10'sd0) begin
         if (exp_in > 10'sd32) begin
            ovf_out = 1'b1;
         end else begin
            shifted = mag_in >> (MAG_W - 1 - int'(exp_in));
            whole   = shifted[32:0];
         end
      end
      // Most negative value is legal: limit is one larger below zero
      if (!ovf_out) begin
         if (sign_in) ovf_out = whole > lim;
         else         ovf_out = whole > (lim - 33'h1);
      end
      if (!ovf_out) begin
         int_out = sign_in ? -$signed(whole[31:0]) : $signed(whole[31:0]);
      end
   end

endmodule // lcx_fix_unit

// ### lcx_pkg.sv
package lcx_pkg;

   // Operation classes presented by the front-end opcode lookup
   typedef enum logic [4:0] {
      LCX_OP_NONE          = 5'h00,
      LCX_OP_FLOAD_SINGLE  = 5'h01,
      LCX_OP_FLOAD_DOUBLE  = 5'h02,
      LCX_OP_FIX_TO_ACC    = 5'h03,
      LCX_OP_FIX_TO_MEM    = 5'h04,
      LCX_OP_WIDE_FIX_ACC  = 5'h05,
      LCX_OP_WIDE_FLT_ACC  = 5'h06,
      LCX_OP_LOAD_FSTAT    = 5'h07,
      LCX_OP_STORE_FSTAT   = 5'h08,
      LCX_OP_LLOAD_FSTAT   = 5'h09,
      LCX_OP_LSTORE_FSTAT  = 5'h0A,
      LCX_OP_RETURN        = 5'h0B,
      LCX_OP_WRETURN       = 5'h0C,
      LCX_OP_WSAVE_STACK   = 5'h0D,
      LCX_OP_WSAVE_RETURN  = 5'h0E,
      LCX_OP_XOP           = 5'h0F,
      LCX_OP_WIDE_EXTENDED_OPERATION_OP          = 5'h10,
      LCX_OP_JUMP          = 5'h11,
      LCX_OP_WJUMP         = 5'h12,
      LCX_OP_BLOCK_MOVE    = 5'h13,
      LCX_OP_FIX_SINGLE    = 5'h14,
      LCX_OP_FIX_DOUBLE    = 5'h15,
      LCX_OP_FLOAT_ARITH   = 5'h16
   } lcx_op_type;

   // Float status register field positions (bit 0 is the most significant)
   localparam int LCX_FSR_W       = 64;
   localparam int LCX_FSR_ANY     = 0;
   localparam int LCX_FSR_MOF     = 4;
   localparam int LCX_FSR_TE      = 5;
   localparam int LCX_FSR_Z       = 6;
   localparam int LCX_FSR_N       = 7;
   localparam int LCX_FSR_RND     = 8;
   localparam int LCX_FSR_FPC_LO  = 33;
   localparam logic [63:0] LCX_FSR_RESET = 64'h0;

   // Program counter layout (bit 0 is the most significant)
   localparam int LCX_PC_SEG_HI   = 1;
   localparam int LCX_PC_SEG_LO   = 3;
   localparam int LCX_PC_ZERO_HI  = 4;
   localparam int LCX_PC_ZERO_LO  = 16;
   localparam int LCX_PC_ADDR_HI  = 17;
   localparam logic [31:0] LCX_PC_RESET = 32'h0;

   // Instruction lengths in words
   localparam logic [1:0] LCX_LEN_ONE   = 2'h1;
   localparam logic [1:0] LCX_LEN_TWO   = 2'h2;
   localparam logic [1:0] LCX_LEN_THREE = 2'h3;

   // Return block size in doublewords for the wide forms
   localparam logic [2:0] LCX_WIDE_RET_BLOCK = 3'h6;

   // Protection code for a descending move crossing a segment
   localparam logic [31:0] LCX_PROT_DESC_CROSS = 32'h4;

   // Integer limits of the fix operations
   localparam logic signed [31:0] LCX_SINGLE_MIN = -32'sd32768;
   localparam logic signed [31:0] LCX_SINGLE_MAX = 32'sd32767;

endpackage

// ### lcx_prog_mem.sv
`timescale 1ns/100ps
// Behavioural main memory: one operand word per low address nibble
module lcx_prog_mem (
   input  wire logic        mclk,
   input  wire logic        rd_en,
   input  wire logic [31:0] addr,
   output logic [63:0]      rd_data
);
   logic [63:0] words [16];
   logic [63:0] last_q;

   // Loaded by the bench before the program steps that read it
   task automatic put(input logic [3:0] slot, input logic [63:0] val);
      words[slot] = val;
   endtask

   initial begin
      for (int i = 0; i < 16; i++) begin
         words[i] = 64'h0;
      end
      last_q = 64'h0;
   end

   // Remember the last word so an idle bus can show its inverse
   always @(posedge mclk) begin
      if (rd_en) begin
         last_q <= rd_data;
      end
   end

   // Idle bus shows inverse of last value, never a stale copy
   assign rd_data = rd_en ? words[addr[3:0]] : ~last_q;
endmodule // lcx_prog_mem

// ### legacy_16bit_compat_execution_tb_top.sv
`timescale 1ns/100ps
module legacy_16bit_compat_execution_tb_top;
   logic mclk = 1'b0, rstn = 1'b0, op_valid = 1'b0, skip_taken = 1'b0, op_done = 1'b0;
   logic blk_descending = 1'b0, blk_cross_seg = 1'b0, flt_exc = 1'b0, psr_mask_in = 1'b0;
   logic flt_result_zero = 1'b0, flt_result_neg = 1'b0;
   lcx_pkg::lcx_op_type op_class = lcx_pkg::LCX_OP_NONE;
   logic [31:0] op_addr = 32'h0, target_addr = 32'h0, acc_operand = 32'h0;
   logic [63:0] mem_operand, float_acc_q, fsr;
   logic [31:0] pc_q, fix_result_q, second_accumulator;
   logic [2:0]  ret_block_dw;
   logic [1:0]  insn_len;
   logic wide_sem, ptr_double, data_wide, use_acc_wide, prot_fault_q, float_trap_q;
   logic nonpriv_fault_q, overflow_trap_mask, narrow_stack, clk_en = 1'b1;
   logic [3:0] sem_flags;
   assign sem_flags = {wide_sem, ptr_double, data_wide, narrow_stack};
   int errors = 0, total_checks = 0;

   always #10 mclk = ~mclk;

   lcx_decoder u_lcx_decoder (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .op_valid(op_valid),
      .op_class(op_class), .op_addr(op_addr), .target_addr(target_addr),
      .skip_taken(skip_taken), .mem_operand(mem_operand), .acc_operand(acc_operand),
      .blk_descending(blk_descending), .blk_cross_seg(blk_cross_seg), .flt_exc(flt_exc),
      .flt_result_zero(flt_result_zero), .flt_result_neg(flt_result_neg), .op_done(op_done),
      .psr_mask_in(psr_mask_in), .insn_len(insn_len), .wide_sem(wide_sem),
      .ptr_double(ptr_double), .data_wide(data_wide), .use_acc_wide(use_acc_wide),
      .ret_block_dw(ret_block_dw), .narrow_stack(narrow_stack), .pc_q(pc_q),
      .float_acc_q(float_acc_q),
      .float_status_register(fsr), .fix_result_q(fix_result_q),
      .second_accumulator(second_accumulator), .prot_fault_q(prot_fault_q),
      .float_trap_q(float_trap_q), .nonpriv_fault_q(nonpriv_fault_q),
      .overflow_trap_mask(overflow_trap_mask));

   lcx_prog_mem u_lcx_prog_mem (.mclk(mclk), .rd_en(op_valid), .addr(op_addr),
      .rd_data(mem_operand));

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Flags: rz, skip, desc, cross, exc, done, mask; held for one taken cycle
   task automatic issue(input lcx_pkg::lcx_op_type c, input logic [31:0] a,
                        input logic [31:0] t, input logic [6:0] f, input logic v);
      @(posedge mclk);
      op_valid <= v;
      op_class <= c;
      op_addr <= a;
      target_addr <= t;
      {flt_result_zero, skip_taken, blk_descending, blk_cross_seg} <= f[6:3];
      {flt_exc, op_done, psr_mask_in} <= f[2:0];
      @(posedge mclk);
      op_valid <= 1'b0;
      op_class <= lcx_pkg::LCX_OP_NONE;
      {flt_result_zero, skip_taken, blk_descending, blk_cross_seg} <= 4'h0;
      {flt_exc, op_done, psr_mask_in} <= 3'h0;
      #1;
   endtask

   // Present a class without retiring it, for the decode outputs
   task automatic peek(input lcx_pkg::lcx_op_type c);
      @(posedge mclk);
      op_class <= c;
      #1;
   endtask

   task automatic give_verdict;
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (5000) @(posedge mclk);
      errors++;
      give_verdict();
   end

   lcx_pkg::lcx_op_type lo[6] = '{lcx_pkg::LCX_OP_LLOAD_FSTAT, lcx_pkg::LCX_OP_LSTORE_FSTAT,
      lcx_pkg::LCX_OP_LOAD_FSTAT, lcx_pkg::LCX_OP_STORE_FSTAT, lcx_pkg::LCX_OP_XOP,
      lcx_pkg::LCX_OP_WIDE_EXTENDED_OPERATION_OP};
   logic [1:0] le[6] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2};
   lcx_pkg::lcx_op_type fo[4] = '{lcx_pkg::LCX_OP_FIX_SINGLE, lcx_pkg::LCX_OP_FIX_SINGLE,
      lcx_pkg::LCX_OP_FIX_DOUBLE, lcx_pkg::LCX_OP_FIX_DOUBLE};
   logic [63:0] fv[4] = '{64'hC480_0000_0000_0000, 64'h447F_FF00_0000_0000,
      64'hC880_0000_0000_0000, 64'h487F_FFFF_FF00_0000};
   logic [31:0] fe[4] = '{32'hFFFF_8000, 32'h0000_7FFF, 32'h8000_0000, 32'h7FFF_FFFF};

   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      chk("pc reset", 64'h0, {32'h0, pc_q});
      chk("fsr reset", 64'h0, fsr);
      // Decode lengths and wide selection per opcode
      for (int i = 0; i < 6; i++) begin
         peek(lo[i]);
         chk("insn_len", {62'h0, le[i]}, {62'h0, insn_len});
      end
      peek(lcx_pkg::LCX_OP_WJUMP);
      chk("wide flags", 64'hE, {60'h0, sem_flags});
      peek(lcx_pkg::LCX_OP_JUMP);
      chk("legacy flags", 64'h1, {60'h0, sem_flags});
      peek(lcx_pkg::LCX_OP_WIDE_FIX_ACC);
      chk("acc wide", 64'h1, {63'h0, use_acc_wide});
      peek(lcx_pkg::LCX_OP_FIX_TO_MEM);
      chk("acc narrow", 64'h0, {63'h0, use_acc_wide});
      peek(lcx_pkg::LCX_OP_WSAVE_STACK);
      chk("ret block", 64'h6, {61'h0, ret_block_dw});
      // Counter loading and no wrap past 7777 octal; segment nibble stays put
      issue(lcx_pkg::LCX_OP_WJUMP, 32'h0, 32'h5ABC_0010, 7'h00, 1'b1);
      chk("pc wide jump", 64'h0ABC_0010, {32'h0, pc_q});
      issue(lcx_pkg::LCX_OP_JUMP, 32'h0, 32'hFFFF_8FFD, 7'h00, 1'b1);
      chk("pc jump", 64'h0FFD, {32'h0, pc_q});
      issue(lcx_pkg::LCX_OP_XOP, 32'h0, 32'h0, 7'h00, 1'b1);
      chk("pc incr", 64'h0FFF, {32'h0, pc_q});
      issue(lcx_pkg::LCX_OP_XOP, 32'h0, 32'h0, 7'h20, 1'b1);
      chk("pc skip", 64'h1002, {32'h0, pc_q});
      issue(lcx_pkg::LCX_OP_NONE, 32'h0, 32'h0, 7'h00, 1'b1);
      chk("pc step", 64'h1003, {32'h0, pc_q});
      // Clock enable low: a presented operation leaves no trace
      @(posedge mclk);
      clk_en <= 1'b0;
      issue(lcx_pkg::LCX_OP_XOP, 32'h0, 32'h0, 7'h00, 1'b1);
      chk("pc frozen", 64'h1003, {32'h0, pc_q});
      @(posedge mclk);
      clk_en <= 1'b1;
      // Loads: impure zero kept, flags from normalized operand; low addresses only
      u_lcx_prog_mem.put(4'h5, 64'h4100_0000_0000_0000);
      u_lcx_prog_mem.put(4'h6, 64'hC110_0000_1234_5678);
      u_lcx_prog_mem.put(4'h7, 64'h0);
      issue(lcx_pkg::LCX_OP_FLOAD_DOUBLE, 32'h5, 32'h0, 7'h00, 1'b1);
      chk("impure zero", 64'h4100_0000_0000_0000, float_acc_q);
      issue(lcx_pkg::LCX_OP_FLOAD_DOUBLE, 32'h7, 32'h0, 7'h00, 1'b1);
      chk("zero flags", 64'h2, {62'h0, fsr[57], fsr[56]});
      issue(lcx_pkg::LCX_OP_FLOAD_SINGLE, 32'h6, 32'h0, 7'h00, 1'b1);
      chk("single load", 64'hC110_0000, {32'h0, float_acc_q[63:32]});
      chk("neg flags", 64'h1, {62'h0, fsr[57], fsr[56]});
      // Fix operations must not touch the zero and negative flags
      issue(lcx_pkg::LCX_OP_FIX_TO_ACC, 32'h6, 32'h0, 7'h40, 1'b1);
      issue(lcx_pkg::LCX_OP_FIX_TO_MEM, 32'h6, 32'h0, 7'h40, 1'b1);
      chk("fix flags", 64'h1, {62'h0, fsr[57], fsr[56]});
      // Range limits, most negative values without mantissa overflow
      for (int i = 0; i < 4; i++) begin
         u_lcx_prog_mem.put(4'h3, fv[i]);
         issue(lcx_pkg::LCX_OP_FLOAD_DOUBLE, 32'h3, 32'h0, 7'h00, 1'b1);
         issue(fo[i], 32'h3, 32'h0, 7'h00, 1'b1);
         chk("fix value", {32'h0, fe[i]}, {32'h0, fix_result_q});
         chk("mof", 64'h0, {63'h0, fsr[59]});
      end
      // Overflow mask only from the wide return and saves
      issue(lcx_pkg::LCX_OP_WRETURN, 32'h0, 32'h0, 7'h01, 1'b1);
      chk("mask ret", 64'h1, {63'h0, overflow_trap_mask});
      issue(lcx_pkg::LCX_OP_WSAVE_STACK, 32'h0, 32'h0, 7'h00, 1'b1);
      chk("mask sav", 64'h0, {63'h0, overflow_trap_mask});
      issue(lcx_pkg::LCX_OP_WSAVE_RETURN, 32'h0, 32'h0, 7'h01, 1'b1);
      issue(lcx_pkg::LCX_OP_RETURN, 32'h0, 32'h0, 7'h00, 1'b1);
      chk("mask legacy", 64'h1, {63'h0, overflow_trap_mask});
      // Descending block move across a segment faults, ascending does not
      issue(lcx_pkg::LCX_OP_BLOCK_MOVE, 32'h0, 32'h0, 7'h18, 1'b1);
      chk("prot fault", 64'h3, {62'h0, prot_fault_q, nonpriv_fault_q});
      chk("prot code", 64'h4, {32'h0, second_accumulator});
      issue(lcx_pkg::LCX_OP_BLOCK_MOVE, 32'h0, 32'h0, 7'h08, 1'b1);
      chk("no fault", 64'h0, {63'h0, prot_fault_q});
      // Status load enables traps; trap at completion holds first address
      u_lcx_prog_mem.put(4'h9, 64'h0480_0000_0000_0000);
      issue(lcx_pkg::LCX_OP_LOAD_FSTAT, 32'h9, 32'h0, 7'h00, 1'b1);
      chk("te rnd", 64'h3, {62'h0, fsr[58], fsr[55]});
      issue(lcx_pkg::LCX_OP_FLOAT_ARITH, 32'h0000_1234, 32'h0, 7'h04, 1'b1);
      issue(lcx_pkg::LCX_OP_FLOAT_ARITH, 32'h0000_2342, 32'h0, 7'h04, 1'b1);
      chk("no early trap", 64'h0, {63'h0, float_trap_q});
      issue(lcx_pkg::LCX_OP_NONE, 32'h0, 32'h0, 7'h02, 1'b0);
      chk("trap", 64'h1, {63'h0, float_trap_q});
      chk("fault addr", 64'h1234, {33'h0, fsr[30:0]});
      give_verdict();
   end
endmodule // legacy_16bit_compat_execution_tb_top
